/* File: inc/ibtq_pkg.sv */
/*
 * Shared constants for the image block transfer queue: register map,
 * field positions, encodings, reset values and sizes.
 * Assumes a single clock domain and a 32-bit register port.
 */
`default_nettype none

package ibtq_pkg;

    ////////////////////////////////////////////////////////////////////
    // sizes
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int TAG_W = 16;
    localparam int QDEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int IRQ_W = 3;

    ////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_BLOCKS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CAPACITY = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_OCCUPANCY = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LOST = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h20;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h24;

    ////////////////////////////////////////////////////////////////////
    // control register fields and values
    localparam int CTRL_METHOD_LSB = 0;
    localparam int CTRL_OPER_BIT = 2;
    localparam int CTRL_POLICY_LSB = 4;
    localparam logic [1:0] METHOD_BASIC = 2'h0;
    localparam logic [1:0] METHOD_AUTO = 2'h1;
    localparam logic [1:0] METHOD_USER = 2'h2;
    localparam logic OPER_CONT = 1'h0;
    localparam logic OPER_MULTI = 1'h1;
    localparam logic [1:0] POLICY_OLDEST_FIRST = 2'h0;

    ////////////////////////////////////////////////////////////////////
    // command, status and interrupt bits
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_HALT_BIT = 1;
    localparam int CMD_CLOSE_BIT = 2;
    localparam int STAT_STREAM_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_REMAIN_LSB = 16;
    localparam int IRQ_LOST_BIT = 0;
    localparam int IRQ_SENT_BIT = 1;
    localparam int IRQ_DONE_BIT = 2;

    ////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0] METHOD_RST = 2'h0;
    localparam logic OPER_RST = 1'h0;
    localparam logic [15:0] BLOCKS_RST = 16'h0001;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

endpackage

`default_nettype wire

/* File: hw/ibtq_queue.sv */
/*
 * Block descriptor queue, oldest first, with overwrite of the oldest
 * entry when full and a per-entry flag that marks the first packet ready.
 * Assumes the caller pops only when the head is ready.
 */
`default_nettype none

module ibtq_queue (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic [ibtq_pkg::TAG_W-1:0] pushTag,
    input wire logic mark,
    input wire logic pop,
    // state
    output logic headReady,
    output logic [ibtq_pkg::TAG_W-1:0] headTag,
    output logic [ibtq_pkg::CNT_W-1:0] count,
    output logic overwrite
);

    function automatic logic [ibtq_pkg::PTR_W-1:0] ptrInc(
        input logic [ibtq_pkg::PTR_W-1:0] p);
        ptrInc = p + 3'h1;
    endfunction

    logic [ibtq_pkg::TAG_W-1:0] tagArr [ibtq_pkg::QDEPTH];
    logic [ibtq_pkg::QDEPTH-1:0] rdy_r;
    logic [ibtq_pkg::PTR_W-1:0] head_r;
    logic [ibtq_pkg::PTR_W-1:0] tail_r;
    logic [ibtq_pkg::CNT_W-1:0] count_r;

    wire logic full = (count_r == 4'h8);
    wire logic empty = (count_r == 4'h0);
    wire logic doPop = pop && headReady;
    wire logic advHead = doPop || overwrite;
    wire logic [ibtq_pkg::PTR_W-1:0] newest = tail_r - 3'h1;

    assign headReady = !empty && rdy_r[head_r];
    assign headTag = tagArr[head_r];
    assign count = count_r;
    assign overwrite = push && full && !doPop;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            tagArr[tail_r] <= pushTag;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            head_r <= 3'h0;
            tail_r <= 3'h0;
            count_r <= 4'h0;
            rdy_r <= 8'h00;
        end else begin
            if (mark && !empty) begin
                rdy_r[newest] <= 1'b1;
            end
            if (push) begin
                rdy_r[tail_r] <= 1'b0;
                tail_r <= ptrInc(tail_r);
            end
            if (advHead) begin
                head_r <= ptrInc(head_r);
            end
            count_r <= count_r + {3'h0, push} - {3'h0, advHead};
        end
    end

endmodule

`default_nettype wire

/* File: hw/ibtq_top.sv */
/*
 * Image block transfer queue: takes blocks from processing at block start,
 * queues their descriptors oldest first and hands them one at a time to
 * the link-layer transmitter under basic, automatic or user control.
 * Assumes processing and transmitter run on ref_clk; software uses a
 * plain strobe port with read data one cycle after the read strobe.
 */
`default_nettype none

// Functional notes
// [R1] basic/automatic send once first packet ready
// [R2] user method follows operation mode and commands
// [R3] user continuous streams, commands gate streaming only
// [R4] multi-block sends programmed count then halts
// [R5] writable block count setting held
// [R6] block count used only in multi-block
// [R7] capacity readable, fixed
// [R8] current occupancy readable
// [R9] lost block count readable
// [R10] queue policy selectable, oldest first only
// [R11] go command starts streaming
// [R12] halt stops after current block finishes
// [R13] go/halt accepted only under user method
// [R14] basic/automatic ignore go and halt
// [R15] full queue overwrites oldest unsent block
// [R16] each overwrite bumps lost counter
// [R17] acquisition start/stop leaves queue untouched
// [R18] closing channel flushes queue, cancels pending
module ibtq_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [ibtq_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ibtq_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [ibtq_pkg::DATA_W-1:0] regRdData,
    // blocks from processing
    input wire logic blkStart,
    input wire logic [ibtq_pkg::TAG_W-1:0] blkTag,
    input wire logic blkPktAvail,
    // stream channel to transmitter
    output logic txValid,
    output logic [ibtq_pkg::TAG_W-1:0] txTag,
    input wire logic txReady,
    input wire logic txDone,
    // interrupt
    output logic irq
);

    typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_BUSY} ibtq_tx_e;

    ////////////////////////////////////////////////////////////////////
    // state
    logic [1:0] xfer_method_select_r;
    logic xfer_operation_select_r;
    logic [1:0] queue_policy_r;
    logic [15:0] blocks_to_send_r;
    logic [15:0] remain_r;
    logic streamOn_r;
    logic [ibtq_pkg::DATA_W-1:0] lost_block_counter_r;
    logic [ibtq_pkg::IRQ_W-1:0] irqStat_r;
    logic [ibtq_pkg::IRQ_W-1:0] irqEn_r;
    logic [ibtq_pkg::DATA_W-1:0] regRdData_r;
    logic irq_r;
    logic txValid_r;
    logic [ibtq_pkg::TAG_W-1:0] txTag_r;
    ibtq_tx_e txState_r;

    logic headReady;
    logic [ibtq_pkg::TAG_W-1:0] headTag;
    logic [ibtq_pkg::CNT_W-1:0] queue_occupancy;
    logic overwrite;

    ////////////////////////////////////////////////////////////////////
    // register decode
    wire logic wrCtrl = regWr && (regAddr == ibtq_pkg::REG_CTRL);
    wire logic wrBlocks = regWr && (regAddr == ibtq_pkg::REG_BLOCKS);
    wire logic wrCmd = regWr && (regAddr == ibtq_pkg::REG_CMD);
    wire logic wrIrqClr = regWr && (regAddr == ibtq_pkg::REG_IRQ_CLR);
    wire logic wrIrqEn = regWr && (regAddr == ibtq_pkg::REG_IRQ_EN);

    wire logic [1:0] wrMethod = regWrData[ibtq_pkg::CTRL_METHOD_LSB +: 2];
    wire logic [1:0] wrPolicy = regWrData[ibtq_pkg::CTRL_POLICY_LSB +: 2];
    wire logic methodLegal = (wrMethod != 2'h3);
    wire logic policyLegal = (wrPolicy == ibtq_pkg::POLICY_OLDEST_FIRST);

    ////////////////////////////////////////////////////////////////////
    // mode and command qualification
    wire logic isUser = (xfer_method_select_r == ibtq_pkg::METHOD_USER);
    wire logic isMulti = isUser && (xfer_operation_select_r == ibtq_pkg::OPER_MULTI);
    wire logic stream_go_cmd = wrCmd && regWrData[ibtq_pkg::CMD_GO_BIT] && isUser; // [R13] [R14]
    wire logic stream_halt_cmd = wrCmd && regWrData[ibtq_pkg::CMD_HALT_BIT]
        && isUser; // [R13] [R14]
    wire logic closeCmd = wrCmd && regWrData[ibtq_pkg::CMD_CLOSE_BIT];
    wire logic goValid = stream_go_cmd && !(isMulti && (blocks_to_send_r == 16'h0000)); // [R6]

    // automatic methods always send, user method only while streaming
    wire logic sendAllowed = !isUser || streamOn_r; // [R1] [R2] [R3]
    wire logic startBlk = (txState_r == TX_IDLE) && headReady && sendAllowed && !closeCmd; // [R1]
    wire logic lastOfRun = startBlk && isMulti && (remain_r == 16'h0001); // [R4]
    wire logic blkSent = (txState_r == TX_BUSY) && txDone;

    ////////////////////////////////////////////////////////////////////
    // descriptor queue
    ibtq_queue u_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(closeCmd), // [R18]
        .push(blkStart), // [R17]
        .pushTag(blkTag),
        .mark(blkPktAvail),
        .pop(startBlk), // [R10]
        .headReady(headReady),
        .headTag(headTag),
        .count(queue_occupancy),
        .overwrite(overwrite) // [R15]
    );

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xfer_method_select_r <= ibtq_pkg::METHOD_RST;
        end else if (wrCtrl && methodLegal) begin
            xfer_method_select_r <= wrMethod;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xfer_operation_select_r <= ibtq_pkg::OPER_RST;
        end else if (wrCtrl) begin
            xfer_operation_select_r <= regWrData[ibtq_pkg::CTRL_OPER_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            queue_policy_r <= ibtq_pkg::POLICY_OLDEST_FIRST;
        end else if (wrCtrl && policyLegal) begin
            queue_policy_r <= wrPolicy; // [R10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blocks_to_send_r <= ibtq_pkg::BLOCKS_RST;
        end else if (wrBlocks) begin
            blocks_to_send_r <= regWrData[15:0]; // [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // streaming gate and multi-block counter
    always_ff @(posedge ref_clk) begin
        if (rst || closeCmd) begin
            streamOn_r <= 1'b0; // [R18]
        end else if (stream_halt_cmd) begin
            streamOn_r <= 1'b0; // [R12]
        end else if (goValid) begin
            streamOn_r <= 1'b1; // [R11]
        end else if (lastOfRun) begin
            streamOn_r <= 1'b0; // [R4]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remain_r <= 16'h0000;
        end else if (goValid && isMulti && !stream_halt_cmd) begin
            remain_r <= blocks_to_send_r; // [R4] [R6]
        end else if (startBlk && isMulti && (remain_r != 16'h0000)) begin
            remain_r <= remain_r - 16'h0001; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter handshake
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txState_r <= TX_IDLE;
            txValid_r <= 1'b0;
        end else begin
            case (txState_r)
                TX_IDLE: begin
                    if (startBlk) begin
                        txState_r <= TX_OFFER;
                        txValid_r <= 1'b1;
                    end
                end
                TX_OFFER: begin
                    if (closeCmd) begin
                        txState_r <= TX_IDLE; // [R18]
                        txValid_r <= 1'b0;
                    end else if (txReady) begin
                        txState_r <= TX_BUSY;
                        txValid_r <= 1'b0;
                    end
                end
                TX_BUSY: begin
                    if (txDone) begin
                        txState_r <= TX_IDLE; // [R12]
                    end
                end
                default: begin
                    txState_r <= TX_IDLE;
                    txValid_r <= 1'b0;
                end
            endcase
        end
    end

    // offered descriptor, captured at the offer decision
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txTag_r <= 16'h0000;
        end else if (startBlk) begin
            txTag_r <= headTag; // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lost block counter, survives acquisition start and stop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lost_block_counter_r <= 32'h0000_0000;
        end else if (overwrite) begin
            lost_block_counter_r <= lost_block_counter_r + 32'h0000_0001; // [R9] [R16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupts: events set, clear write drops, set wins
    wire logic [ibtq_pkg::IRQ_W-1:0] irqEvt = {lastOfRun, blkSent, overwrite};
    wire logic [ibtq_pkg::IRQ_W-1:0] irqClr = wrIrqClr ? regWrData[ibtq_pkg::IRQ_W-1:0] : 3'h0;
    wire logic [ibtq_pkg::IRQ_W-1:0] irqStat_nxt = (irqStat_r & ~irqClr) | irqEvt;
    wire logic [ibtq_pkg::IRQ_W-1:0] irqEn_nxt = wrIrqEn ? regWrData[ibtq_pkg::IRQ_W-1:0] : irqEn_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStat_r <= 3'h0;
        end else begin
            irqStat_r <= irqStat_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqEn_r <= ibtq_pkg::IRQ_EN_RST;
        end else begin
            irqEn_r <= irqEn_nxt;
        end
    end

    // level output follows the next status and enable values
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irqStat_nxt & irqEn_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    wire logic [ibtq_pkg::DATA_W-1:0] ctrlVal = {26'h0, queue_policy_r, 1'b0,
        xfer_operation_select_r, xfer_method_select_r};
    wire logic [ibtq_pkg::DATA_W-1:0] statusVal = {remain_r, 14'h0,
        (txState_r != TX_IDLE), streamOn_r};
    wire logic [ibtq_pkg::DATA_W-1:0] queue_capacity = 32'h0000_0008; // [R7]

    wire logic [ibtq_pkg::DATA_W-1:0] rdMux =
        (regAddr == ibtq_pkg::REG_CTRL) ? ctrlVal :
        (regAddr == ibtq_pkg::REG_BLOCKS) ? {16'h0, blocks_to_send_r} :
        (regAddr == ibtq_pkg::REG_CAPACITY) ? queue_capacity : // [R7]
        (regAddr == ibtq_pkg::REG_OCCUPANCY) ? {28'h0, queue_occupancy} : // [R8]
        (regAddr == ibtq_pkg::REG_LOST) ? lost_block_counter_r : // [R9]
        (regAddr == ibtq_pkg::REG_STATUS) ? statusVal :
        (regAddr == ibtq_pkg::REG_IRQ_STAT) ? {29'h0, irqStat_r} :
        (regAddr == ibtq_pkg::REG_IRQ_EN) ? {29'h0, irqEn_r} :
        32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdData_r <= 32'h0000_0000;
        end else if (regRd) begin
            regRdData_r <= rdMux;
        end else begin
            regRdData_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign regRdData = regRdData_r;
    assign txValid = txValid_r;
    assign txTag = txTag_r;
    assign irq = irq_r;

endmodule

`default_nettype wire

/* File: dv/ibtq_top_asserts.sv */
/*
 * Checker for ibtq_top: register read timing and stream offer handshake.
 * Assumes one ref_clk domain and a bind onto every ibtq_top instance.
 */
`default_nettype none

module ibtq_top_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [ibtq_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ibtq_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [ibtq_pkg::DATA_W-1:0] regRdData,
    // blocks from processing
    input wire logic blkStart,
    input wire logic [ibtq_pkg::TAG_W-1:0] blkTag,
    input wire logic blkPktAvail,
    // stream channel
    input wire logic txValid,
    input wire logic [ibtq_pkg::TAG_W-1:0] txTag,
    input wire logic txReady,
    input wire logic txDone,
    // interrupt
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic inFlight_r;
    logic closeCmd;
    assign closeCmd = regWr && regAddr == ibtq_pkg::REG_CMD && regWrData[ibtq_pkg::CMD_CLOSE_BIT];

    ////////////////////////////////////////////////////////////////////
    // accepted block still with the transmitter
    always_ff @(posedge ref_clk) begin
        if (rst) inFlight_r <= 1'b0;
        else if (txValid && txReady) inFlight_r <= 1'b1;
        else if (txDone) inFlight_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_offer_holds: assert property (
        txValid && !txReady && !closeCmd |=> txValid && $stable(txTag))
        else $error("offer dropped or changed before acceptance");
    a_accept_ends: assert property (txValid && txReady |=> !txValid)
        else $error("offer still up after acceptance");
    a_one_block: assert property (inFlight_r |-> !txValid)
        else $error("new offer while a block is in flight");
    a_idle_rdata: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside read answer");
    a_capacity_val: assert property (
        regRd && regAddr == ibtq_pkg::REG_CAPACITY |=> regRdData == 32'h00000008)
        else $error("capacity value wrong");
    a_occ_bound: assert property (
        regRd && regAddr == ibtq_pkg::REG_OCCUPANCY |=> regRdData <= 32'h00000008)
        else $error("occupancy above capacity");
    a_irq_off: assert property (
        regWr && regAddr == ibtq_pkg::REG_IRQ_EN && regWrData[2:0] == 3'h0 |=> !irq)
        else $error("interrupt high with all enables off");
    a_status_busy: assert property (
        regRd && regAddr == ibtq_pkg::REG_STATUS && (txValid || inFlight_r) |=> regRdData[1])
        else $error("status busy bit low while a block is offered or in flight");
endmodule

bind ibtq_top ibtq_top_asserts ibtq_top_asserts_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .blkStart(blkStart), .blkTag(blkTag),
    .blkPktAvail(blkPktAvail), .txValid(txValid), .txTag(txTag), .txReady(txReady),
    .txDone(txDone), .irq(irq)
);

`default_nettype wire

/* File: dv/ibtq_tx_sink.sv */
/*
 * Link-layer transmitter model: accepts offers after a delay, then ends each block.
 * Assumes ref_clk and rst of the block; lag sets both delays in cycles.
 */
`default_nettype none

module ibtq_tx_sink (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // offer side
    input wire logic txValid,
    input wire logic [7:0] lag,
    // answers
    output logic txReady,
    output logic txDone
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] waitCnt;
    logic busy;

    always @(posedge ref_clk) begin
        txDone <= 1'b0;
        if (rst) begin
            txReady <= 1'b0;
            busy <= 1'b0;
            waitCnt <= lag;
        end else if (txValid && txReady) begin
            txReady <= 1'b0;
            busy <= 1'b1;
            waitCnt <= lag;
        end else if (busy) begin
            if (waitCnt == 8'h00) begin
                busy <= 1'b0;
                txDone <= 1'b1;
                waitCnt <= lag;
            end else waitCnt <= waitCnt - 8'h01;
        end else if (txValid) begin
            if (waitCnt == 8'h00) txReady <= 1'b1;
            else waitCnt <= waitCnt - 8'h01;
        end else txReady <= 1'b0;
    end
endmodule

`default_nettype wire

/* File: dv/tb.sv */
/*
 * Self-checking bench for ibtq_top with the transmitter model.
 * Assumes the package is compiled first and the checker is bound.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk, rst, regWr, regRd, blkStart, blkPktAvail, txValid, txReady, txDone, irq;
    logic [7:0] regAddr, lag;
    logic [31:0] regWrData, regRdData;
    logic [15:0] blkTag, txTag;
    logic [15:0] sent[$];
    int doneCount = 0;
    int bad_count = 0;
    int tests_run = 0;

    ibtq_top ibtq_top_inst (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .blkStart(blkStart), .blkTag(blkTag),
        .blkPktAvail(blkPktAvail), .txValid(txValid), .txTag(txTag), .txReady(txReady),
        .txDone(txDone), .irq(irq)
    );
    ibtq_tx_sink ibtq_tx_sink_inst (
        .ref_clk(ref_clk), .rst(rst), .txValid(txValid), .lag(lag), .txReady(txReady),
        .txDone(txDone)
    );

    always @(posedge ref_clk) begin
        if (!rst && txValid && txReady) sent.push_back(txTag);
        if (!rst && txDone) doneCount++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    task automatic blk(input logic [15:0] tag, input logic mark);
        @(posedge ref_clk);
        blkStart <= 1'b1;
        blkTag <= tag;
        @(posedge ref_clk);
        blkStart <= 1'b0;
        blkPktAvail <= mark;
        @(posedge ref_clk);
        blkPktAvail <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(ibtq_pkg::REG_CAPACITY, 32'h00000008);
        rd(ibtq_pkg::REG_OCCUPANCY, 32'h00000000);
        rd(ibtq_pkg::REG_LOST, 32'h00000000);
        rd(ibtq_pkg::REG_BLOCKS, 32'h00000001);
        wr(ibtq_pkg::REG_BLOCKS, 32'h00000005);
        rd(ibtq_pkg::REG_BLOCKS, 32'h00000005);
        wr(ibtq_pkg::REG_CTRL, 32'h00000010);
        rd(ibtq_pkg::REG_CTRL, 32'h00000000);
        wr(ibtq_pkg::REG_CAPACITY, 32'h00000003);
        rd(ibtq_pkg::REG_CAPACITY, 32'h00000008);
        rd(8'h28, 32'h00000000);
        $display("test regs done");
    endtask

    task automatic t_basic;
        for (int m = 0; m < 2; m++) begin
            sent.delete();
            wr(ibtq_pkg::REG_CTRL, 32'(m));
            wr(ibtq_pkg::REG_CMD, 32'h00000002);
            for (int i = 0; i < 3; i++) blk(16'hA000 + 16'(m * 16 + i), 1'b1);
            idle(60);
            chk(32'(sent.size()), 32'h00000003);
            for (int i = 0; i < 3; i++) chk(sent[i], 16'hA000 + 16'(m * 16 + i));
        end
        $display("test basic done");
    endtask

    task automatic t_overflow;
        for (int i = 0; i < 10; i++) blk(16'hB000 + 16'(i), 1'b0);
        rd(ibtq_pkg::REG_OCCUPANCY, 32'h00000008);
        rd(ibtq_pkg::REG_LOST, 32'h00000002);
        wr(ibtq_pkg::REG_IRQ_EN, 32'h00000001);
        idle(2);
        chk(irq, 1'b1);
        wr(ibtq_pkg::REG_IRQ_CLR, 32'h00000001);
        idle(2);
        chk(irq, 1'b0);
        wr(ibtq_pkg::REG_IRQ_EN, 32'h00000000);
        wr(ibtq_pkg::REG_CMD, 32'h00000004);
        rd(ibtq_pkg::REG_OCCUPANCY, 32'h00000000);
        $display("test overflow done");
    endtask

    task automatic t_multi;
        sent.delete();
        wr(ibtq_pkg::REG_CTRL, 32'h00000006);
        wr(ibtq_pkg::REG_BLOCKS, 32'h00000002);
        for (int i = 0; i < 3; i++) blk(16'hC000 + 16'(i), 1'b1);
        idle(20);
        chk(32'(sent.size()), 32'h00000000);
        wr(ibtq_pkg::REG_CMD, 32'h00000001);
        idle(60);
        chk(32'(sent.size()), 32'h00000002);
        chk(sent[0], 16'hC000);
        rd(ibtq_pkg::REG_OCCUPANCY, 32'h00000001);
        rd(ibtq_pkg::REG_STATUS, 32'h00000000);
        rd(ibtq_pkg::REG_IRQ_STAT, 32'h00000006);
        wr(ibtq_pkg::REG_CMD, 32'h00000004);
        $display("test multi done");
    endtask

    task automatic t_cont;
        int d0;
        d0 = doneCount;
        sent.delete();
        wr(ibtq_pkg::REG_CTRL, 32'h00000002);
        wr(ibtq_pkg::REG_BLOCKS, 32'h00000001);
        wr(ibtq_pkg::REG_CMD, 32'h00000001);
        for (int i = 0; i < 3; i++) blk(16'hD000 + 16'(i), 1'b1);
        idle(60);
        chk(32'(sent.size()), 32'h00000003);
        lag <= 8'h1E;
        blk(16'hD003, 1'b1);
        for (int i = 0; i < 200 && sent.size() < 4; i++) @(posedge ref_clk);
        rd(ibtq_pkg::REG_STATUS, 32'h00000003);
        wr(ibtq_pkg::REG_CMD, 32'h00000002);
        blk(16'hD004, 1'b1);
        idle(100);
        chk(32'(sent.size()), 32'h00000004);
        chk(32'(doneCount - d0), 32'h00000004);
        rd(ibtq_pkg::REG_OCCUPANCY, 32'h00000001);
        wr(ibtq_pkg::REG_CMD, 32'h00000004);
        lag <= 8'h02;
        $display("test cont done");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        final_report;
    end

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 32'h00000000;
        regWr = 1'b0;
        regRd = 1'b0;
        blkStart = 1'b0;
        blkTag = 16'h0000;
        blkPktAvail = 1'b0;
        lag = 8'h02;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_basic;
        t_overflow;
        t_multi;
        t_cont;
        final_report;
    end
endmodule

`default_nettype wire
